// file: plb_status_diag.sv
// Indicator drive, carrier and collision, loopback, self-test and management registers
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE1 - Mode field: bit5 set gives mode 1, 00 mode 2, 10 mode 3.
// RULE2 - Mode 1 link indicator on with good link, off without.
// RULE3 - 10M link after seven consecutive link pulses or one valid packet.
// RULE4 - Link indicator drops only when the link loss timer expires; at 100 Mb/s the code drops it as soon as sd100_in falls, with no timer.
// RULE5 - Modes 2 and 3: link indicator steady on, blinks on activity.
// RULE6 - Rate indicator on at 100 Mb/s, off at 10, every mode.
// RULE7 - Mode 1 activity indicator shows transmit or receive activity.
// RULE8 - Mode 2 activity indicator shows collision.
// RULE9 - Mode 3 activity indicator shows full duplex.
// RULE10 - Collision indication uses the same collision sent to the MAC.
// RULE11 - Strap low gives active-high indicator, strap high active-low.
// RULE12 - Override register forces indicators; reading it never returns pin states.
// RULE13 - Half duplex: carrier sense on transmit or receive activity.
// RULE14 - Full duplex: no collision, carrier sense on receive only.
// RULE15 - Loopback routes MII transmit to receive; nothing goes to media.
// RULE16 - Status register bit reports loopback state.
// RULE17 - Agent should disable auto-negotiation before enabling loopback.
// RULE18 - Self-test sends pseudo-random stream, 9 or 15 bit selectable.
// RULE19 - Self-test receiver compares against its own local sequence.
// RULE20 - Status resets fail, passes on compare; mis-compare latches until start write.
// RULE21 - Continuous-mode bit makes self-test transmit without gaps.
// RULE22 - Eight-bit error count in upper byte of diagnostic register.
// RULE23 - Blink toggles link indicator at fixed rate while activity lasts.
// RULE24 - Error counter saturates and clears when a new test starts.
module plb_status_diag
	import plb_pkg::*;
#(
	parameter int LOSS_CYC = LINK_LOSS_CYC,
	parameter int BLINK_PER = BLINK_CYC
) (
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	input wire logic [4:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	output logic [15:0] reg_rdata_out,
	input wire logic [LED_NUM-1:0] led_strap_in,
	input wire logic nlp_in,
	input wire logic pkt10_in,
	input wire logic sd100_in,
	input wire logic speed100_in,
	input wire logic full_duplex_in,
	input wire logic mii_tx_en_in,
	input wire logic [3:0] mii_txd_in,
	input wire logic med_rx_dv_in,
	input wire logic [3:0] med_rxd_in,
	output logic mii_rx_dv_out,
	output logic [3:0] mii_rxd_out,
	output logic mii_crs_out,
	output logic mii_col_out,
	output logic med_tx_en_out,
	output logic [3:0] med_txd_out,
	output logic link_indicator_out,
	output logic rate_indicator_out,
	output logic activity_collision_indicator_out
);
	localparam int BW = $clog2(BLINK_PER + 1);
	localparam logic [7:0] ST_LAST = 8'(ST_PKT_NIBBLES + ST_GAP_NIBBLES - 1);

	function automatic plb_mode_t mode_of(input logic [1:0] f);
		return f[0] ? PLB_MODE1 : (f[1] ? PLB_MODE3 : PLB_MODE2);
	endfunction : mode_of

	logic lb_reg;
	logic [5:0] ledovr_reg;
	logic [1:0] mode_reg;
	logic len15_reg;
	logic start_reg;
	logic cont_reg;
	logic pass_reg;
	logic latch_reg;
	logic [7:0] err_reg;
	logic [7:0] st_pos_reg;
	logic lb_dv_reg;
	logic [3:0] lb_d_reg;
	logic [LED_NUM-1:0] strap_reg;
	logic strap_done_reg;
	logic [BW-1:0] blink_cnt_reg;
	logic blink_on_reg;
	logic [LED_NUM-1:0] led_reg;

	logic wr_bmc, wr_ledovr, wr_phyctl, wr_diag;
	logic st_new, st_tx_en, st_restart;
	logic [3:0] st_txd, rx_ref;
	logic tx_en, rx_dv;
	logic [3:0] txd, rxd;
	logic cmp_valid, cmp_bad, cmp_good;
	logic latch_eff, pass_next, latch_next;
	logic [7:0] err_next;
	logic link_up, activity, collision;
	plb_mode_t mode;
	logic [LED_NUM-1:0] led_func, led_logic;
	logic [15:0] rd_mux;
	logic blink_wrap;

	// Register decode
	assign wr_bmc = reg_wr_in && (reg_addr_in == BMC_ADDR);
	assign wr_ledovr = reg_wr_in && (reg_addr_in == LEDOVR_ADDR);
	assign wr_phyctl = reg_wr_in && (reg_addr_in == PHYCTL_ADDR);
	assign wr_diag = reg_wr_in && (reg_addr_in == DIAG1_ADDR);
	assign st_new = wr_phyctl && reg_wdata_in[PHYCTL_START_BIT] && !start_reg;

	// Self-test transmit framing
	assign st_tx_en = start_reg && (cont_reg || st_pos_reg < 8'(ST_PKT_NIBBLES)); // see RULE21
	assign st_restart = !st_tx_en;

	plb_lfsr u_tx_lfsr (
		.ref_clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.len15_in(len15_reg),
		.restart_in(st_restart),
		.step_in(st_tx_en),
		.data_out(st_txd)
	);

	// Transmit source and loopback path
	assign tx_en = start_reg ? st_tx_en : mii_tx_en_in;
	assign txd = start_reg ? st_txd : mii_txd_in;
	assign rx_dv = lb_reg ? lb_dv_reg : med_rx_dv_in; // see RULE15
	assign rxd = lb_reg ? lb_d_reg : med_rxd_in;

	// Receiver reference runs only on received nibbles
	plb_lfsr u_rx_lfsr (
		.ref_clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.len15_in(len15_reg),
		.restart_in(!rx_dv),
		.step_in(rx_dv),
		.data_out(rx_ref)
	);

	assign cmp_valid = start_reg && rx_dv;
	assign cmp_bad = cmp_valid && (rxd != rx_ref); // see RULE19
	assign cmp_good = cmp_valid && (rxd == rx_ref);
	// Mis-compare wins over a clearing write in the same cycle
	assign latch_eff = latch_reg && !wr_phyctl;
	assign latch_next = cmp_bad || latch_eff; // see RULE20
	assign pass_next = !cmp_bad && ((pass_reg && !st_new) || (cmp_good && !latch_eff));
	assign err_next = st_new ? {7'h00, cmp_bad} :
		((cmp_bad && err_reg != ERR_MAX) ? err_reg + 8'h01 : err_reg); // see RULE24

	plb_link_mon #(
		.LOSS_CYC(LOSS_CYC)
	) u_link (
		.ref_clk_in(ref_clk_in),
		.arst_n_in(arst_n_in),
		.nlp_in(nlp_in),
		.pkt10_in(pkt10_in),
		.sd100_in(sd100_in),
		.speed100_in(speed100_in),
		.link_out(link_up)
	);

	// Carrier and collision; loopback is never a collision
	assign activity = tx_en || rx_dv;
	assign collision = !full_duplex_in && !lb_reg && tx_en && rx_dv; // see RULE14

	// Indicator functions
	assign mode = mode_of(mode_reg); // see RULE1
	assign blink_wrap = (blink_cnt_reg == BW'(BLINK_PER - 1));
	assign led_func[LED_LINKUP] = (mode == PLB_MODE1) ? link_up :
		(link_up && (!activity || blink_on_reg)); // see RULE2, see RULE5
	assign led_func[LED_RATE] = speed100_in; // see RULE6
	assign led_func[LED_ACT] = (mode == PLB_MODE1) ? activity : // see RULE7
		((mode == PLB_MODE2) ? collision : full_duplex_in); // see RULE8, see RULE9, see RULE10

	genvar gi;
	generate
		for (gi = 0; gi < LED_NUM; gi++) begin : g_led
			assign led_logic[gi] = ledovr_reg[LEDOVR_EN_LSB + gi] ?
				ledovr_reg[LEDOVR_VAL_LSB + gi] : led_func[gi]; // see RULE12
		end
	endgenerate

	// Read mux; the override register returns its own contents only
	always_comb begin
		rd_mux = 16'h0000;
		case (reg_addr_in)
			BMC_ADDR: rd_mux[BMC_LB_BIT] = lb_reg;
			STS_ADDR: begin
				rd_mux[STS_LINK_BIT] = link_up;
				rd_mux[STS_SPD10_BIT] = !speed100_in;
				rd_mux[STS_FDX_BIT] = full_duplex_in;
				rd_mux[STS_LB_BIT] = lb_reg; // see RULE16
			end
			LEDOVR_ADDR: rd_mux[LEDOVR_VAL_LSB +: 2 * LED_NUM] = ledovr_reg;
			PHYCTL_ADDR: begin
				rd_mux[PHYCTL_MODE_LSB +: 2] = mode_reg;
				rd_mux[PHYCTL_STAT_BIT] = pass_reg;
				rd_mux[PHYCTL_LEN15_BIT] = len15_reg;
				rd_mux[PHYCTL_START_BIT] = start_reg;
			end
			DIAG1_ADDR: begin
				rd_mux[DIAG_ERR_LSB +: 8] = err_reg; // see RULE22
				rd_mux[DIAG_CONT_BIT] = cont_reg;
			end
			default: rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			lb_reg <= 1'b0;
			ledovr_reg <= 6'h00;
			mode_reg <= PHYCTL_MODE_RST;
			len15_reg <= 1'b0;
			start_reg <= 1'b0;
			cont_reg <= 1'b0;
		end else begin
			if (wr_bmc) lb_reg <= reg_wdata_in[BMC_LB_BIT];
			if (wr_ledovr) ledovr_reg <= reg_wdata_in[LEDOVR_VAL_LSB +: 2 * LED_NUM];
			if (wr_phyctl) begin
				mode_reg <= reg_wdata_in[PHYCTL_MODE_LSB +: 2];
				len15_reg <= reg_wdata_in[PHYCTL_LEN15_BIT]; // see RULE18
				start_reg <= reg_wdata_in[PHYCTL_START_BIT];
			end
			if (wr_diag) cont_reg <= reg_wdata_in[DIAG_CONT_BIT];
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pass_reg <= 1'b0;
			latch_reg <= 1'b0;
			err_reg <= 8'h00;
			st_pos_reg <= 8'h00;
			lb_dv_reg <= 1'b0;
			lb_d_reg <= 4'h0;
		end else begin
			pass_reg <= pass_next;
			latch_reg <= latch_next;
			err_reg <= err_next;
			st_pos_reg <= (!start_reg || st_pos_reg == ST_LAST) ? 8'h00 : st_pos_reg + 8'h01;
			lb_dv_reg <= tx_en;
			lb_d_reg <= txd;
		end
	end

	// Strap is caught on the first edge after reset release
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			strap_done_reg <= 1'b0;
			strap_reg <= '0;
		end else if (!strap_done_reg) begin
			strap_done_reg <= 1'b1;
			strap_reg <= led_strap_in;
		end
	end

	// Blink phase restarts on so an idle link shows steady on
	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			blink_cnt_reg <= '0;
			blink_on_reg <= 1'b1;
		end else if (!activity) begin
			blink_cnt_reg <= '0;
			blink_on_reg <= 1'b1;
		end else begin
			blink_cnt_reg <= blink_wrap ? '0 : blink_cnt_reg + 1'b1;
			if (blink_wrap) blink_on_reg <= !blink_on_reg; // see RULE23
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			led_reg <= '0;
			reg_rdata_out <= 16'h0000;
			mii_rx_dv_out <= 1'b0;
			mii_rxd_out <= 4'h0;
			mii_crs_out <= 1'b0;
			mii_col_out <= 1'b0;
			med_tx_en_out <= 1'b0;
			med_txd_out <= 4'h0;
		end else begin
			led_reg <= strap_done_reg ? (led_logic ^ strap_reg) : '0; // see RULE11
			reg_rdata_out <= rd_mux;
			mii_rx_dv_out <= rx_dv;
			mii_rxd_out <= rxd;
			mii_crs_out <= full_duplex_in ? rx_dv : activity; // see RULE13, see RULE14
			mii_col_out <= collision;
			med_tx_en_out <= tx_en && !lb_reg; // see RULE15
			med_txd_out <= lb_reg ? 4'h0 : txd;
		end
	end

	assign link_indicator_out = led_reg[LED_LINKUP];
	assign rate_indicator_out = led_reg[LED_RATE];
	assign activity_collision_indicator_out = led_reg[LED_ACT];

	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!arst_n_in);

	sequence s_lb_send;
		lb_reg && !wr_bmc && tx_en;
	endsequence
	sequence s_lb_seen;
		!med_tx_en_out ##1 mii_rx_dv_out;
	endsequence

	a_loop_path: assert property (s_lb_send |=> s_lb_seen) else $error("loopback path broken"); // see RULE15
	a_lb_status: assert property (reg_addr_in == STS_ADDR |=> reg_rdata_out[STS_LB_BIT] == $past(lb_reg))
		else $error("loopback status wrong"); // see RULE16
	a_rate_led: assert property (strap_done_reg && !ledovr_reg[LEDOVR_EN_LSB + LED_RATE]
		|=> rate_indicator_out == ($past(speed100_in) ^ strap_reg[LED_RATE])) else $error("rate indicator wrong"); // see RULE6
	a_mode1_act: assert property (strap_done_reg && mode_reg[0] && !ledovr_reg[LEDOVR_EN_LSB + LED_ACT]
		|=> activity_collision_indicator_out == ($past(activity) ^ strap_reg[LED_ACT])) else $error("mode 1 act"); // see RULE7
	a_mode2_col: assert property (strap_done_reg && mode_reg == 2'b00 && !ledovr_reg[LEDOVR_EN_LSB + LED_ACT]
		|=> activity_collision_indicator_out == (mii_col_out ^ strap_reg[LED_ACT])) else $error("mode 2 col"); // see RULE8
	a_mode3_fdx: assert property (strap_done_reg && mode_reg == 2'b10 && !ledovr_reg[LEDOVR_EN_LSB + LED_ACT]
		|=> activity_collision_indicator_out == ($past(full_duplex_in) ^ strap_reg[LED_ACT])) else $error("mode 3"); // see RULE9
	a_link_steady: assert property (strap_done_reg && !mode_reg[0] && link_up && !activity
		&& !ledovr_reg[LEDOVR_EN_LSB + LED_LINKUP] |=> link_indicator_out == !strap_reg[LED_LINKUP])
		else $error("link not steady"); // see RULE5
	a_crs_half: assert property (!full_duplex_in && (tx_en || rx_dv) |=> mii_crs_out) else $error("crs missing"); // see RULE13
	a_full_nocol: assert property (full_duplex_in |=> !mii_col_out) else $error("collision in full duplex"); // see RULE14
	a_fail_latch: assert property (cmp_bad ##1 !wr_phyctl [*2] |=> !pass_reg && latch_reg)
		else $error("fail not latched"); // see RULE20
	a_err_sat: assert property (err_reg == ERR_MAX && !st_new |=> err_reg == ERR_MAX) else $error("count wrapped"); // see RULE24
endmodule : plb_status_diag
`default_nettype wire

// file: plb_pkg.sv
// Shared constants and types for the transceiver status, loopback and self-test logic
package plb_pkg;
	// Management register numbers
	localparam logic [4:0] BMC_ADDR = 5'h00;
	localparam logic [4:0] STS_ADDR = 5'h10;
	localparam logic [4:0] LEDOVR_ADDR = 5'h18;
	localparam logic [4:0] PHYCTL_ADDR = 5'h19;
	localparam logic [4:0] DIAG1_ADDR = 5'h1B;
	// Field positions
	localparam int BMC_LB_BIT = 14;
	localparam int STS_LINK_BIT = 0;
	localparam int STS_SPD10_BIT = 1;
	localparam int STS_FDX_BIT = 2;
	localparam int STS_LB_BIT = 3;
	localparam int LEDOVR_VAL_LSB = 0;
	localparam int LEDOVR_EN_LSB = 3;
	localparam int PHYCTL_MODE_LSB = 5;
	localparam int PHYCTL_STAT_BIT = 8;
	localparam int PHYCTL_LEN15_BIT = 11;
	localparam int PHYCTL_START_BIT = 13;
	localparam int DIAG_CONT_BIT = 5;
	localparam int DIAG_ERR_LSB = 8;
	// Indicator indices
	localparam int LED_LINKUP = 0;
	localparam int LED_RATE = 1;
	localparam int LED_ACT = 2;
	localparam int LED_NUM = 3;
	// Reset values and error count limit
	localparam logic [1:0] PHYCTL_MODE_RST = 2'h1;
	localparam logic [7:0] ERR_MAX = 8'hFF;
	localparam logic [14:0] LFSR_SEED = 15'h7FFF;
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int LINK_LOSS_MS = 50;
	localparam int BLINK_MS = 50;
	localparam int LINK_LOSS_CYC = LINK_LOSS_MS * 1000000 / CLK_PERIOD_NS;
	localparam int BLINK_CYC = BLINK_MS * 1000000 / CLK_PERIOD_NS;
	localparam int NLP_LINK_COUNT = 7;
	localparam int ST_PKT_NIBBLES = 128;
	localparam int ST_GAP_NIBBLES = 24;
	typedef enum logic [1:0] {
		PLB_MODE2 = 2'b00,
		PLB_MODE1 = 2'b01,
		PLB_MODE3 = 2'b10
	} plb_mode_t;
endpackage : plb_pkg

// file: plb_lfsr.sv
// Nibble-wide pseudo-random generator, 9-bit or 15-bit sequence
`timescale 1ns/1ps
`default_nettype none
module plb_lfsr
	import plb_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	input wire logic len15_in,
	input wire logic restart_in,
	input wire logic step_in,
	output logic [3:0] data_out
);
	logic [14:0] state_reg;
	logic [14:0] state_next;

	function automatic logic [14:0] adv4(input logic [14:0] s, input logic l15);
		logic [14:0] t;
		logic fb;
		t = s;
		for (int i = 0; i < 4; i++) begin
			fb = l15 ? (t[14] ^ t[13]) : (t[8] ^ t[4]);
			t = {t[13:0], fb};
		end
		return t;
	endfunction : adv4

	assign state_next = restart_in ? LFSR_SEED : (step_in ? adv4(state_reg, len15_in) : state_reg);
	assign data_out = state_reg[3:0];

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_reg <= LFSR_SEED;
		end else begin
			state_reg <= state_next;
		end
	end
endmodule : plb_lfsr
`default_nettype wire

// file: plb_link_mon.sv
// Link qualification: pulse counting at 10 Mb/s and link loss timing
`timescale 1ns/1ps
`default_nettype none
module plb_link_mon
	import plb_pkg::*;
#(
	parameter int LOSS_CYC = LINK_LOSS_CYC
) (
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	input wire logic nlp_in,
	input wire logic pkt10_in,
	input wire logic sd100_in,
	input wire logic speed100_in,
	output logic link_out
);
	localparam int LW = $clog2(LOSS_CYC + 1);
	logic [LW-1:0] loss_cnt_reg;
	logic [2:0] nlp_cnt_reg;
	logic link10_reg;
	logic seen;
	logic expired;

	assign seen = nlp_in | pkt10_in;
	assign expired = (loss_cnt_reg == LW'(LOSS_CYC));
	assign link_out = speed100_in ? sd100_in : link10_reg;

	always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			loss_cnt_reg <= '0;
			nlp_cnt_reg <= '0;
			link10_reg <= 1'b0;
		end else begin
			loss_cnt_reg <= seen ? '0 : (expired ? loss_cnt_reg : loss_cnt_reg + 1'b1);
			if (expired && !seen) begin
				// Only the loss timer may drop the 10 Mb/s link, see RULE4
				nlp_cnt_reg <= '0;
				link10_reg <= 1'b0;
			end else if (pkt10_in || (nlp_in && nlp_cnt_reg == 3'(NLP_LINK_COUNT - 1))) begin
				link10_reg <= 1'b1; // see RULE3
			end else if (nlp_in) begin
				nlp_cnt_reg <= nlp_cnt_reg + 1'b1;
			end
		end
	end

	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!arst_n_in);
	a_link_hold: assert property (link10_reg && !expired |=> link10_reg) else $error("10M link dropped early"); // see RULE4
	a_link_pkt: assert property (pkt10_in && !expired |=> link10_reg) else $error("packet did not raise link"); // see RULE3
endmodule : plb_link_mon
`default_nettype wire

// file: plb_far_model.sv
// Far-side model: media cable that can loop transmit back, plus receive traffic
`timescale 1ns/1ps
`default_nettype none
module plb_far_model (
	input wire logic ref_clk_in,
	input wire logic cable_in,
	input wire logic corrupt_in,
	input wire logic act_in,
	input wire logic tx_en_in,
	input wire logic [3:0] txd_in,
	output logic rx_dv_out,
	output logic [3:0] rxd_out
);
	initial begin
		rx_dv_out = 1'b0;
		rxd_out = 4'h0;
	end
	always @(posedge ref_clk_in) begin
		rx_dv_out <= cable_in ? tx_en_in : act_in;
		if (cable_in && tx_en_in) begin
			// Low bit flipped on command to provoke mis-compares
			rxd_out <= txd_in ^ {3'h0, corrupt_in};
		end else begin
			// Changing nibble so a stale value never passes as data
			rxd_out <= ~rxd_out;
		end
	end
endmodule : plb_far_model
`default_nettype wire

// file: plb_status_diag_tb.sv
// Testbench for the status, loopback and self-test block
`timescale 1ns/1ps
`default_nettype none
module plb_status_diag_tb;
	import plb_pkg::*;
	localparam int LOSS = 50;
	localparam logic [2:0] STRAP = 3'b010;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [15:0] wd = 16'h0000;
	logic wr = 1'b0;
	logic nlp = 1'b0, pkt = 1'b0, sd = 1'b0, spd = 1'b0, fdx = 1'b0;
	logic tx_en = 1'b0, cable = 1'b0, corrupt = 1'b0, rx_act = 1'b0;
	logic [3:0] txd = 4'h0;
	logic [15:0] rdata;
	logic rx_dv, mrx_dv, crs, col, mtx_en, l_led, r_led, a_led;
	logic [3:0] rxd, mrxd, mtxd;
	int n_fail = 0;
	int n_tests = 0;
	int n;
	logic lo, hi;

	plb_status_diag #(.LOSS_CYC(LOSS), .BLINK_PER(4)) u_plb_status_diag (.ref_clk_in(clk), .arst_n_in(rst_n),
		.reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rdata_out(rdata), .led_strap_in(STRAP),
		.nlp_in(nlp), .pkt10_in(pkt), .sd100_in(sd), .speed100_in(spd), .full_duplex_in(fdx),
		.mii_tx_en_in(tx_en), .mii_txd_in(txd), .med_rx_dv_in(rx_dv), .med_rxd_in(rxd),
		.mii_rx_dv_out(mrx_dv), .mii_rxd_out(mrxd), .mii_crs_out(crs), .mii_col_out(col),
		.med_tx_en_out(mtx_en), .med_txd_out(mtxd), .link_indicator_out(l_led),
		.rate_indicator_out(r_led), .activity_collision_indicator_out(a_led));
	plb_far_model u_plb_far_model (.ref_clk_in(clk), .cable_in(cable), .corrupt_in(corrupt), .act_in(rx_act),
		.tx_en_in(mtx_en), .txd_in(mtxd), .rx_dv_out(rx_dv), .rxd_out(rxd));

	initial begin
		forever #5 clk = ~clk;
	end

	task automatic conclude;
		$display("Checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask : cyc

	task automatic wreg(input logic [4:0] a, input logic [15:0] d);
		addr = a;
		wd = d;
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
		// Idle edge so a following write never retoggles the strobe in one step
		cyc(1);
	endtask : wreg

	task automatic rreg(input logic [4:0] a, input logic [15:0] e, input string nm);
		addr = a;
		cyc(1);
		chk(nm, e, rdata);
	endtask : rreg

	// Expected logic levels {act, rate, link}; pins carry them through strap polarity
	task automatic ind(input logic [2:0] e);
		cyc(3);
		chk("indicators", 16'(e ^ STRAP), 16'({a_led, r_led, l_led}));
	endtask : ind

	task automatic gaps;
		n = 0;
		repeat (200) begin
			cyc(1);
			if (mtx_en !== 1'b1) n++;
		end
	endtask : gaps

	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		conclude();
	end

	initial begin
		repeat (8) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		cyc(2);
		rreg(PHYCTL_ADDR, 16'h0020, "phy_control reset");
		rreg(DIAG1_ADDR, 16'h0000, "diag reset");
		rreg(LEDOVR_ADDR, 16'h0000, "override reset");
		wreg(STS_ADDR, 16'hFFFF);
		rreg(STS_ADDR, 16'h0002, "status read only");
		rreg(5'h05, 16'h0000, "unmapped");
		repeat (6) begin
			nlp = 1'b1;
			cyc(1);
			nlp = 1'b0;
			cyc(1);
		end
		ind(3'b000);
		nlp = 1'b1;
		cyc(1);
		nlp = 1'b0;
		ind(3'b001);
		cyc(20);
		ind(3'b001);
		cyc(35);
		ind(3'b000);
		pkt = 1'b1;
		cyc(1);
		pkt = 1'b0;
		ind(3'b001);
		spd = 1'b1;
		sd = 1'b1;
		ind(3'b011);
		tx_en = 1'b1;
		ind(3'b111);
		tx_en = 1'b0;
		ind(3'b011);
		wreg(PHYCTL_ADDR, 16'h0000);
		tx_en = 1'b1;
		rx_act = 1'b1;
		// Blink phase starts on, so the link stays lit for the first blink period
		ind(3'b111);
		chk("col", 16'h0001, 16'(col));
		lo = 1'b0;
		hi = 1'b0;
		repeat (12) begin
			cyc(1);
			if (l_led === 1'b0) lo = 1'b1;
			if (l_led === 1'b1) hi = 1'b1;
		end
		chk("blink", 16'h0003, 16'({hi, lo}));
		fdx = 1'b1;
		cyc(3);
		chk("col full", 16'h0000, 16'(col));
		chk("crs full rx", 16'h0001, 16'(crs));
		rx_act = 1'b0;
		cyc(3);
		chk("crs full tx", 16'h0000, 16'(crs));
		fdx = 1'b0;
		cyc(3);
		chk("crs half tx", 16'h0001, 16'(crs));
		tx_en = 1'b0;
		ind(3'b011);
		wreg(PHYCTL_ADDR, 16'h0040);
		fdx = 1'b1;
		ind(3'b111);
		fdx = 1'b0;
		ind(3'b011);
		wreg(PHYCTL_ADDR, 16'h0060);
		tx_en = 1'b1;
		ind(3'b111);
		tx_en = 1'b0;
		wreg(LEDOVR_ADDR, 16'h003D);
		ind(3'b101);
		rreg(LEDOVR_ADDR, 16'h003D, "override readback");
		wreg(LEDOVR_ADDR, 16'h0000);
		// Auto-negotiation enable stays clear while loopback is selected
		wreg(BMC_ADDR, 16'h4000);
		rreg(STS_ADDR, 16'h0009, "status loopback");
		tx_en = 1'b1;
		txd = 4'hA;
		cyc(1);
		tx_en = 1'b0;
		chk("media quiet", 16'h0000, 16'(mtx_en));
		cyc(1);
		chk("loop data", 16'h001A, 16'({mrx_dv, mrxd}));
		wreg(PHYCTL_ADDR, 16'h2000);
		cyc(300);
		rreg(PHYCTL_ADDR, 16'h2100, "selftest 9 pass");
		wreg(PHYCTL_ADDR, 16'h0000);
		wreg(PHYCTL_ADDR, 16'h2800);
		cyc(300);
		rreg(PHYCTL_ADDR, 16'h2900, "selftest 15 pass");
		rreg(DIAG1_ADDR, 16'h0000, "no errors");
		wreg(BMC_ADDR, 16'h0000);
		cable = 1'b1;
		corrupt = 1'b1;
		wreg(PHYCTL_ADDR, 16'h0000);
		wreg(PHYCTL_ADDR, 16'h2000);
		cyc(500);
		rreg(DIAG1_ADDR, 16'hFF00, "error saturate");
		corrupt = 1'b0;
		cyc(200);
		rreg(PHYCTL_ADDR, 16'h2000, "fail latched");
		wreg(PHYCTL_ADDR, 16'h0000);
		wreg(PHYCTL_ADDR, 16'h2000);
		cyc(300);
		rreg(DIAG1_ADDR, 16'h0000, "count cleared");
		rreg(PHYCTL_ADDR, 16'h2100, "pass again");
		gaps();
		chk("packet gap", 16'h0001, 16'(n != 0));
		wreg(DIAG1_ADDR, 16'h0020);
		cyc(2);
		gaps();
		chk("continuous", 16'h0000, 16'(n));
		conclude();
	end
endmodule : plb_status_diag_tb
`default_nettype wire
